/* File: bench/testbench.sv */
`timescale 1ns/1ns
module testbench
    import uhi_pkg::*;
;
    logic        clk = 0, arst_n = 0, cpu_wr = 0, cpu_rd = 0, hpi_wr = 0, hpi_rd = 0;
    logic [15:0] cpu_addr = '0, cpu_wdata = '0, hpi_addr = '0, hpi_wdata = '0, cpu_rdata, hpi_rdata;
    logic        vbus_valid, otg_id, pend = 0, port = 0;
    logic [1:0]  line_se0, remote_wake, xfer_done, sof_sent, frame_expired, irq;
    logic [13:0] target_addr;
    logic [21:0] frame_num;
    logic [27:0] frame_count;
    logic [15:0] exp_q[$];
    int          num_errors = 0, n_checks = 0, cyc = 0, seed = 28;
    uhi_top     uut (.*);
    uhi_usb_dev dev (.*);
    always #5 clk = ~clk;
    ////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %0h expected %0h", $time, seen, exp);
        end
    endtask
    // one access, released after the taking edge; the gap edge avoids a double drive
    task automatic acc(input bit h, w, input logic [15:0] a, d, e);
        if (!w) exp_q.push_back(e);
        if (h) {hpi_wr, hpi_rd, hpi_addr, hpi_wdata} <= {w, !w, a, d};
        else {cpu_wr, cpu_rd, cpu_addr, cpu_wdata} <= {w, !w, a, d};
        @(posedge clk);
        {cpu_wr, cpu_rd, hpi_wr, hpi_rd} <= 4'h0;
        @(posedge clk);
    endtask
    task automatic wait_exp(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!frame_expired[0] && n < 101000);
    endtask
    always @(posedge clk) begin
        if (pend) chk(port ? hpi_rdata : cpu_rdata, exp_q.pop_front());
        pend <= cpu_rd | hpi_rd;
        port <= hpi_rd;
        cyc++;
        if (cyc == 110000) begin
            num_errors++;
            give_verdict();
        end
    end
    ////////////////////////////////
    initial begin
        logic [15:0] d;
        int          n;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        chk(frame_count, {UHI_RELOAD_RST, UHI_RELOAD_RST});
        acc(0, 0, UHI_ENABLE_1_OFS, 0, UHI_ENABLE_RST);
        acc(1, 0, UHI_RELOAD_2_OFS, 0, {2'b00, UHI_RELOAD_RST});
        acc(0, 0, UHI_STATUS_1_OFS, 0, 16'h0004);
        acc(0, 0, UHI_ADDR_1_OFS, 0, 16'h0000);
        $display("reset values done");
        for (int i = 0; i < 4; i++) begin
            d = 16'($random(seed));
            acc(i[0], 1, i[1] ? UHI_ENABLE_2_OFS : UHI_ENABLE_1_OFS, d, 0);
            acc(!i[0], 0, i[1] ? UHI_ENABLE_2_OFS : UHI_ENABLE_1_OFS, 0, d & (i[1] ? UHI_MASK_NOOTG : UHI_MASK_FULL));
        end
        acc(0, 1, UHI_ENABLE_1_OFS, 16'hFFFF, 0);
        acc(1, 1, UHI_ENABLE_2_OFS, 16'hFFFF, 0);
        d = 16'($random(seed));
        acc(1, 1, UHI_ADDR_1_OFS, d, 0);
        acc(0, 1, UHI_ADDR_2_OFS, ~d, 0);
        chk(target_addr, {~d[6:0], d[6:0]});
        $display("register access done");
        dev.plug(0, 1);
        dev.plug(1, 1);
        for (int k = 0; k < 4; k++) dev.pulse(k / 2, k % 2);
        dev.otg_flip();
        repeat (3) @(posedge clk);
        acc(0, 0, UHI_STATUS_1_OFS, 0, 16'hC051);
        acc(1, 0, UHI_STATUS_2_OFS, 0, 16'h0051);
        chk(irq, 2'b11);
        acc(1, 1, UHI_STATUS_1_OFS, 16'h0041, 0);
        acc(0, 0, UHI_STATUS_1_OFS, 0, 16'hC010);
        acc(0, 1, UHI_STATUS_1_OFS, 16'h0000, 0);
        acc(1, 0, UHI_STATUS_1_OFS, 0, 16'hC010);
        acc(0, 1, UHI_STATUS_1_OFS, 16'hFFFF, 0);
        chk(irq[0], 1'b0);
        acc(1, 1, UHI_ENABLE_2_OFS, 16'h0000, 0);
        chk(irq[1], 1'b0);
        acc(1, 0, UHI_STATUS_2_OFS, 0, 16'h0051);
        dev.plug(0, 0);
        repeat (3) @(posedge clk);
        acc(0, 0, UHI_STATUS_1_OFS, 0, 16'h0014);
        acc(0, 1, UHI_STATUS_1_OFS, 16'h0010, 0);
        $display("event flags done");
        repeat (3) dev.pulse(0, 2);
        dev.pulse(1, 2);
        @(posedge clk);
        chk(frame_num, {11'h001, 11'h003});
        acc(0, 1, UHI_RELOAD_1_OFS, 16'hFFFF, 0);
        chk(frame_num[10:0], 11'h000);
        acc(1, 0, UHI_RELOAD_1_OFS, 0, 16'h3FFF);
        acc(0, 1, UHI_RELOAD_1_OFS, 16'h000F, 0);
        // the new count only loads at the next zero, so the first frame is full length
        wait_exp(n);
        chk(frame_expired, 2'b11);
        wait_exp(n);
        chk(n >= 124 && n <= 126, 1'b1);
        acc(1, 0, UHI_STATUS_1_OFS, 0, 16'h0204);
        chk(irq[0], 1'b1);
        $display("frame timer done");
        give_verdict();
    end
endmodule

/* File: bench/uhi_top_sva.sv */
`timescale 1ns/1ns
module uhi_top_sva
    import uhi_pkg::*;
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        cpu_wr,
    input wire logic        cpu_rd,
    input wire logic [15:0] cpu_addr,
    input wire logic [15:0] cpu_rdata,
    input wire logic        hpi_wr,
    input wire logic        hpi_rd,
    input wire logic [15:0] hpi_addr,
    input wire logic [15:0] hpi_wdata,
    input wire logic [15:0] hpi_rdata,
    input wire logic [1:0]  sof_sent,
    input wire logic [13:0] target_addr,
    input wire logic [21:0] frame_num,
    input wire logic [27:0] frame_count,
    input wire logic [1:0]  frame_expired,
    input wire logic [1:0]  irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic rl_w;
    // host port wins a clash, the processor write is then lost
    assign rl_w = (hpi_wr && hpi_addr == UHI_RELOAD_1_OFS) || (cpu_wr && !hpi_wr && cpu_addr == UHI_RELOAD_1_OFS);
    ////////////////////////////////
    AST_ADDR_WR: assert property (
        hpi_wr && hpi_addr == UHI_ADDR_1_OFS |=> target_addr[6:0] == $past(hpi_wdata[6:0])) else $error("addr lost");
    AST_ADDR_RD: assert property (
        cpu_rd && cpu_addr == UHI_ADDR_1_OFS |=> cpu_rdata == 16'h0000) else $error("addr readable");
    AST_CPU_HOLD: assert property (
        !$past(cpu_rd) |-> $stable(cpu_rdata)) else $error("cpu rdata moved");
    AST_HPI_HOLD: assert property (
        !$past(hpi_rd) |-> $stable(hpi_rdata)) else $error("hpi rdata moved");
    AST_IRQ_FALL: assert property (
        |($past(irq) & ~irq) |-> $past(cpu_wr || hpi_wr)) else $error("irq fell unasked");
    AST_FRAME_CLR: assert property (
        rl_w && !sof_sent[0] |=> frame_num[10:0] == 11'h000) else $error("frame not cleared");
    AST_FRAME_ADV: assert property (
        sof_sent[0] && !rl_w |=> frame_num[10:0] == $past(frame_num[10:0]) + 11'h001) else $error("frame stuck");
    AST_EXP_ZERO: assert property (
        frame_expired[0] |-> frame_count[13:0] <= 14'h0001) else $error("expiry off zero");
    AST_TICK_GAP: assert property (
        $changed(frame_count[13:0]) |=> $stable(frame_count[13:0])[*7]) else $error("tick too fast");
    AST_DOWN: assert property (
        $changed(frame_count[13:0]) && !$past(frame_expired[0])
        |-> frame_count[13:0] == $past(frame_count[13:0]) - 14'h0001) else $error("count skipped");
endmodule
bind uhi_top uhi_top_sva chk_i (.*);

/* File: bench/uhi_usb_dev.sv */
`timescale 1ns/1ns
module uhi_usb_dev (
    input  wire logic       clk,
    output logic      [1:0] line_se0,
    output logic      [1:0] remote_wake,
    output logic      [1:0] xfer_done,
    output logic      [1:0] sof_sent,
    output logic            vbus_valid,
    output logic            otg_id
);
    // empty ports sit in SE0 through the host pull-downs
    initial begin
        line_se0 = 2'h3;
        {remote_wake, xfer_done, sof_sent} = 6'h00;
        {vbus_valid, otg_id} = 2'b01;
    end
    task automatic plug(input int e, input logic on);
        @(posedge clk);
        line_se0[e] <= ~on;
    endtask
    // k: 0 wakeup, 1 transfer outcome, else frame mark
    task automatic pulse(input int e, input int k);
        @(posedge clk);
        case (k)
            0: remote_wake[e] <= 1'b1;
            1: xfer_done[e] <= 1'b1;
            default: sof_sent[e] <= 1'b1;
        endcase
        @(posedge clk);
        {remote_wake[e], xfer_done[e], sof_sent[e]} <= 3'h0;
    endtask
    task automatic otg_flip();
        @(posedge clk);
        {vbus_valid, otg_id} <= {~vbus_valid, ~otg_id};
    endtask
endmodule

/* File: hw/uhi_engine.sv */
`timescale 1ns/1ns
module uhi_engine
    import uhi_pkg::*;
#(
    parameter bit HAS_OTG = 1'b1
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        tick_12m,
    input  wire logic        wr_enable,
    input  wire logic        wr_status,
    input  wire logic        wr_reload,
    input  wire logic        wr_addr,
    input  wire logic [15:0] wdata,
    input  wire logic        vbus_valid,
    input  wire logic        otg_id,
    input  wire logic        line_se0,
    input  wire logic        remote_wake,
    input  wire logic        xfer_done,
    input  wire logic        sof_sent,
    output logic      [15:0] enable_rd,
    output logic      [15:0] status_rd,
    output logic      [15:0] reload_rd,
    output logic      [6:0]  target_addr,
    output logic      [10:0] frame_num,
    output logic      [13:0] frame_count,
    output logic             frame_expired,
    output logic             irq
);
    import uhi_pkg::*;

    typedef struct packed {
        logic [15:0] en;
        logic [15:0] flag;
        logic [13:0] reload;
        logic [13:0] cnt;
        logic [6:0]  addr;
        logic [10:0] frame;
        logic        vbus;
        logic        id;
        logic        se0;
        logic        primed;
    } uhi_eng_s;

    localparam logic [15:0] MASK = HAS_OTG ? UHI_MASK_FULL : UHI_MASK_NOOTG;

    uhi_eng_s s_q;
    uhi_eng_s s_d;
    logic     expire;
    logic [15:0] ev;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d    = s_q;
        // reload on the tick that reaches zero, so a frame lasts exactly reload ticks
        expire = tick_12m && (s_q.cnt <= 14'h0001);
        ev     = 16'h0000;
        // edge detectors wait one cycle after reset so strap levels do not fire
        ev[UHI_BIT_VBUS] = s_q.primed && (vbus_valid != s_q.vbus);
        ev[UHI_BIT_ID]   = s_q.primed && (otg_id != s_q.id);
        ev[UHI_BIT_SOF]  = expire;
        ev[UHI_BIT_WAKE] = remote_wake;
        ev[UHI_BIT_CONN] = s_q.primed && (line_se0 != s_q.se0);
        ev[UHI_BIT_DONE] = xfer_done;
        s_d.primed = 1'b1;
        s_d.vbus   = vbus_valid;
        s_d.id     = otg_id;
        s_d.se0    = line_se0;
        if (wr_enable) begin
            s_d.en = wdata & MASK;
        end
        // set wins over a same-cycle clear; flags set regardless of enable
        if (wr_status) begin
            s_d.flag = s_q.flag & ~wdata;
        end
        s_d.flag = (s_d.flag | ev) & MASK;
        if (wr_addr) begin
            s_d.addr = wdata[6:0];
        end
        if (tick_12m) begin
            s_d.cnt = expire ? s_q.reload : s_q.cnt - 14'h0001;
        end
        if (sof_sent) begin
            s_d.frame = s_q.frame + 11'h001;
        end
        if (wr_reload) begin
            s_d.reload = wdata[13:0];
            s_d.frame  = UHI_FRAME_RST;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '{en: UHI_ENABLE_RST, flag: 16'h0000, reload: UHI_RELOAD_RST, cnt: UHI_RELOAD_RST,
                     addr: UHI_ADDR_RST, frame: UHI_FRAME_RST, vbus: 1'b0, id: 1'b0, se0: 1'b0,
                     primed: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        status_rd = s_q.flag;
        status_rd[UHI_BIT_SE0] = s_q.se0;
    end
    assign enable_rd     = s_q.en;
    assign reload_rd     = {2'b00, s_q.reload};
    assign target_addr   = s_q.addr;
    assign frame_num     = s_q.frame;
    assign frame_count   = s_q.cnt;
    assign frame_expired = expire;
    assign irq           = |(s_q.flag & s_q.en);
endmodule

/* File: hw/uhi_pkg.sv */
package uhi_pkg;
    localparam logic [15:0] UHI_ENABLE_1_OFS = 16'hC08C;
    localparam logic [15:0] UHI_STATUS_1_OFS = 16'hC090;
    localparam logic [15:0] UHI_RELOAD_1_OFS = 16'hC092;
    localparam logic [15:0] UHI_ENABLE_2_OFS = 16'hC0AC;
    localparam logic [15:0] UHI_STATUS_2_OFS = 16'hC0B0;
    localparam logic [15:0] UHI_RELOAD_2_OFS = 16'hC0B2;
    localparam logic [15:0] UHI_ADDR_1_OFS   = 16'hC088;
    localparam logic [15:0] UHI_ADDR_2_OFS   = 16'hC0A8;
    localparam int          UHI_BIT_VBUS     = 15;
    localparam int          UHI_BIT_ID       = 14;
    localparam int          UHI_BIT_SOF      = 9;
    localparam int          UHI_BIT_WAKE     = 6;
    localparam int          UHI_BIT_CONN     = 4;
    localparam int          UHI_BIT_SE0      = 2;
    localparam int          UHI_BIT_DONE     = 0;
    localparam logic [15:0] UHI_MASK_FULL    = 16'hC251;
    localparam logic [15:0] UHI_MASK_NOOTG   = 16'h0251;
    localparam logic [13:0] UHI_RELOAD_RST   = 14'h2EE0;
    localparam logic [15:0] UHI_ENABLE_RST   = 16'h0000;
    localparam logic [6:0]  UHI_ADDR_RST     = 7'h00;
    localparam logic [10:0] UHI_FRAME_RST    = 11'h000;
    localparam int          UHI_CLK_HZ       = 100_000_000;
    localparam int          UHI_TICK_HZ      = 12_000_000;
    // 100/12 is not whole: a phase accumulator gives the exact average rate
    localparam logic [7:0]  UHI_TICK_INC     = 8'(UHI_TICK_HZ / 4_000_000);
    localparam logic [7:0]  UHI_TICK_MOD     = 8'(UHI_CLK_HZ / 4_000_000);
endpackage

/* File: hw/uhi_top.sv */
`timescale 1ns/1ns
module uhi_top
    import uhi_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_rd,
    input  wire logic [15:0] cpu_addr,
    input  wire logic [15:0] cpu_wdata,
    output logic      [15:0] cpu_rdata,
    input  wire logic        hpi_wr,
    input  wire logic        hpi_rd,
    input  wire logic [15:0] hpi_addr,
    input  wire logic [15:0] hpi_wdata,
    output logic      [15:0] hpi_rdata,
    input  wire logic        vbus_valid,
    input  wire logic        otg_id,
    input  wire logic [1:0]  line_se0,
    input  wire logic [1:0]  remote_wake,
    input  wire logic [1:0]  xfer_done,
    input  wire logic [1:0]  sof_sent,
    output logic      [13:0] target_addr,
    output logic      [21:0] frame_num,
    output logic      [27:0] frame_count,
    output logic      [1:0]  frame_expired,
    output logic      [1:0]  irq
);
    import uhi_pkg::*;

    typedef struct packed {
        logic [7:0]  phase;
        logic        tick;
        logic [15:0] cpu_rdata;
        logic [15:0] hpi_rdata;
    } uhi_top_s;

    uhi_top_s t_q;
    uhi_top_s t_d;
    logic [15:0] enable_rd [2];
    logic [15:0] status_rd [2];
    logic [15:0] reload_rd [2];
    // parallel host port wins a same-cycle write clash with the internal processor
    logic        wr_any;
    logic [15:0] wa;
    logic [15:0] wd;

    function automatic logic [15:0] rd_mux(input logic [15:0] a, input logic [15:0] e1,
                                           input logic [15:0] s1, input logic [15:0] r1,
                                           input logic [15:0] e2, input logic [15:0] s2,
                                           input logic [15:0] r2);
        case (a)
            UHI_ENABLE_1_OFS: rd_mux = e1;
            UHI_STATUS_1_OFS: rd_mux = s1;
            UHI_RELOAD_1_OFS: rd_mux = r1;
            UHI_ENABLE_2_OFS: rd_mux = e2;
            UHI_STATUS_2_OFS: rd_mux = s2;
            UHI_RELOAD_2_OFS: rd_mux = r2;
            default:          rd_mux = 16'h0000;
        endcase
    endfunction

    assign wr_any = hpi_wr | cpu_wr;
    assign wa     = hpi_wr ? hpi_addr : cpu_addr;
    assign wd     = hpi_wr ? hpi_wdata : cpu_wdata;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        t_d = t_q;
        t_d.tick = 1'b0;
        if (t_q.phase + UHI_TICK_INC >= UHI_TICK_MOD) begin
            t_d.phase = t_q.phase + UHI_TICK_INC - UHI_TICK_MOD;
            t_d.tick  = 1'b1;
        end else begin
            t_d.phase = t_q.phase + UHI_TICK_INC;
        end
        if (cpu_rd) begin
            t_d.cpu_rdata = rd_mux(cpu_addr, enable_rd[0], status_rd[0], reload_rd[0],
                                   enable_rd[1], status_rd[1], reload_rd[1]);
        end
        if (hpi_rd) begin
            t_d.hpi_rdata = rd_mux(hpi_addr, enable_rd[0], status_rd[0], reload_rd[0],
                                   enable_rd[1], status_rd[1], reload_rd[1]);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            t_q <= '0;
        end else begin
            t_q <= t_d;
        end
    end

    assign cpu_rdata = t_q.cpu_rdata;
    assign hpi_rdata = t_q.hpi_rdata;

    ////////////////////////////////////////////////////////////////////////
    for (genvar g = 0; g < 2; g++) begin : g_eng
        localparam logic [15:0] EN_OFS = (g == 0) ? UHI_ENABLE_1_OFS : UHI_ENABLE_2_OFS;
        localparam logic [15:0] ST_OFS = (g == 0) ? UHI_STATUS_1_OFS : UHI_STATUS_2_OFS;
        localparam logic [15:0] RL_OFS = (g == 0) ? UHI_RELOAD_1_OFS : UHI_RELOAD_2_OFS;
        localparam logic [15:0] AD_OFS = (g == 0) ? UHI_ADDR_1_OFS : UHI_ADDR_2_OFS;
        uhi_engine #(
            .HAS_OTG (g == 0)
        ) u_eng (
            .clk           (clk),
            .arst_n        (arst_n),
            .tick_12m      (t_q.tick),
            .wr_enable     (wr_any && wa == EN_OFS),
            .wr_status     (wr_any && wa == ST_OFS),
            .wr_reload     (wr_any && wa == RL_OFS),
            .wr_addr       (wr_any && wa == AD_OFS),
            .wdata         (wd),
            .vbus_valid    ((g == 0) ? vbus_valid : 1'b0),
            .otg_id        ((g == 0) ? otg_id : 1'b0),
            .line_se0      (line_se0[g]),
            .remote_wake   (remote_wake[g]),
            .xfer_done     (xfer_done[g]),
            .sof_sent      (sof_sent[g]),
            .enable_rd     (enable_rd[g]),
            .status_rd     (status_rd[g]),
            .reload_rd     (reload_rd[g]),
            .target_addr   (target_addr[g*7 +: 7]),
            .frame_num     (frame_num[g*11 +: 11]),
            .frame_count   (frame_count[g*14 +: 14]),
            .frame_expired (frame_expired[g]),
            .irq           (irq[g])
        );
    end
endmodule
